/* File: hdl/perf_monitor_pkg.sv */
// Constants, register map and carrier types for the counter snapshot bank.
// Assumes one link, a 40 MHz core clock and an AXI4-Lite register bus.
//
// Function
// - All twelve mapping registers refresh together as one group, never singly.
// - A 0-to-1 edge of snapshot_request loads every mapping register at once.
// - With auto_snapshot_enable set, reload all mapping registers once per second.
// - ESF keeps a 10-bit CRC-6 error count: low byte 00H, bits 9:8 at 01H[5:4].
// - SF, digital-data, SLC-96 keep 12-bit framing bit errors: 02H and 03H[3:0].
// - In ESF the framing counter instead counts frame alignment bit errors.
// - Count framing position changes in a 3-bit field at 04H[2:0].
// - Count sync loss events in a 5-bit field at 05H[4:0], all formats.
// - Keep a 16-bit pattern receiver bit error count at 06H and 07H.
// - Keep a 16-bit line code violation count at 08H and 09H.
// - Digital-data format keeps a 10-bit data service error count: 0AH and 0BH[1:0].
package perf_monitor_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CRC_LOW      = 6'h00;
  localparam logic [5:0] IDX_CRC_HIGH     = 6'h01;
  localparam logic [5:0] IDX_FRAMING_LOW  = 6'h02;
  localparam logic [5:0] IDX_FRAMING_HIGH = 6'h03;
  localparam logic [5:0] IDX_ALIGN_CHANGE = 6'h04;
  localparam logic [5:0] IDX_SYNC_LOSS    = 6'h05;
  localparam logic [5:0] IDX_PATTERN_LOW  = 6'h06;
  localparam logic [5:0] IDX_PATTERN_HIGH = 6'h07;
  localparam logic [5:0] IDX_LCV_LOW      = 6'h08;
  localparam logic [5:0] IDX_LCV_HIGH     = 6'h09;
  localparam logic [5:0] IDX_DDS_LOW      = 6'h0A;
  localparam logic [5:0] IDX_DDS_HIGH     = 6'h0B;
  localparam logic [5:0] IDX_CONTROL      = 6'h10;
  localparam logic [5:0] IDX_FORMAT       = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS   = 6'h12;
  localparam logic [5:0] IDX_IRQ_MASK     = 6'h13;

  localparam int ADDR_W = 8;
  localparam int INDEX_LSB = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_AUTO_BIT    = 0;
  localparam int CTRL_REQUEST_BIT = 1;
  localparam int CRC_HIGH_LSB     = 4;
  localparam int IRQ_SNAPSHOT_BIT = 0;
  localparam int IRQ_WRAP_BIT     = 1;
  localparam int IRQ_W            = 2;

  // ----------------------------------------------------------------
  // Counter widths
  // ----------------------------------------------------------------
  localparam int CRC_W     = 10;
  localparam int FRAMING_W = 12;
  localparam int ALIGN_W   = 3;
  localparam int SYNC_W    = 5;
  localparam int PATTERN_W = 16;
  localparam int LCV_W     = 16;
  localparam int DDS_W     = 10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ       = 40000000;
  localparam longint SECOND_MS      = 1000;
  localparam longint SECOND_CYCLES  = CLOCK_HZ * SECOND_MS / 1000;

  // ----------------------------------------------------------------
  // AXI responses and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    FMT_SF,
    FMT_ESF,
    FMT_DIGITAL_DATA,
    FMT_SLC96
  } frame_format_type;

  // Event strobes from the framer, one cycle each
  typedef struct packed {
    logic crc_error;
    logic framing_error;
    logic alignment_change;
    logic sync_loss;
    logic pattern_error;
    logic line_code_violation;
    logic data_service_error;
  } event_strobe_type;

  // Snapshot image of every live counter
  typedef struct packed {
    logic [CRC_W-1:0]     crc;
    logic [FRAMING_W-1:0] framing;
    logic [ALIGN_W-1:0]   align;
    logic [SYNC_W-1:0]    sync;
    logic [PATTERN_W-1:0] pattern;
    logic [LCV_W-1:0]     line_code_violation_count;
    logic [DDS_W-1:0]     dds;
  } counter_set_type;

endpackage

/* File: hdl/event_counter.sv */
// Saturation-free event counter, cleared as the group is captured.
// Assumes the clear strobe comes from the snapshot logic.
module event_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             event_in,
  input  wire logic             clear_in,
  output logic      [WIDTH-1:0] count_out
);

  // An event in the capture cycle starts the new interval rather than being lost
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      count_out <= '0;
    else if (clear_in)
      count_out <= WIDTH'(event_in);
    else if (event_in)
      count_out <= count_out + WIDTH'(1);
  end

endmodule

/* File: hdl/perf_monitor.sv */
// Performance monitor counter snapshot bank for one framer link.
// Assumes single-cycle event strobes synchronous to core_clk_in.
module perf_monitor #(
  parameter longint SECOND_CYCLES = perf_monitor_pkg::SECOND_CYCLES
) (
  input  wire logic                               core_clk_in,
  input  wire logic                               rst_in,
  input  wire perf_monitor_pkg::event_strobe_type events_in,
  input  wire logic [7:0]                         s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [7:0]                         s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic                                    irq_out
);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic                                  auto_snapshot_enable_r;
  logic                                  snapshot_request_r;
  perf_monitor_pkg::frame_format_type    format_r;
  logic [perf_monitor_pkg::IRQ_W-1:0]    irq_status_r;
  logic [perf_monitor_pkg::IRQ_W-1:0]    irq_mask_r;
  logic [31:0]                           second_count_r;
  perf_monitor_pkg::counter_set_type     live;
  perf_monitor_pkg::counter_set_type     snap_r;
  logic                                  capture;
  logic                                  second_tick;
  logic                                  request_rise;
  logic                                  any_full;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_write;
  logic [5:0]  w_index;

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign w_index  = aw_addr_r[perf_monitor_pkg::INDEX_LSB +: 6];

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= perf_monitor_pkg::ZERO_WORD;
      w_strb_r      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= perf_monitor_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (w_index)
          perf_monitor_pkg::IDX_CONTROL,
          perf_monitor_pkg::IDX_FORMAT,
          perf_monitor_pkg::IDX_IRQ_STATUS,
          perf_monitor_pkg::IDX_IRQ_MASK: s_axi_bresp <= perf_monitor_pkg::RESP_OKAY;
          default:                        s_axi_bresp <= perf_monitor_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and format registers
  // ----------------------------------------------------------------
  logic ctrl_write;
  assign ctrl_write = do_write && w_strb_r[0] && (w_index == perf_monitor_pkg::IDX_CONTROL);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      auto_snapshot_enable_r <= 1'b0;
      snapshot_request_r     <= 1'b0;
      format_r               <= perf_monitor_pkg::FMT_SF;
      irq_mask_r             <= '0;
    end
    else if (do_write && w_strb_r[0])
    begin
      case (w_index)
        perf_monitor_pkg::IDX_CONTROL:
        begin
          auto_snapshot_enable_r <= w_data_r[perf_monitor_pkg::CTRL_AUTO_BIT];
          snapshot_request_r     <= w_data_r[perf_monitor_pkg::CTRL_REQUEST_BIT];
        end
        perf_monitor_pkg::IDX_FORMAT:
          format_r <= perf_monitor_pkg::frame_format_type'(w_data_r[1:0]);
        perf_monitor_pkg::IDX_IRQ_MASK:
          irq_mask_r <= w_data_r[perf_monitor_pkg::IRQ_W-1:0];
        default:
          ;
      endcase
    end
  end

  // Only a written 0-to-1 change triggers; rewriting a 1 does nothing
  assign request_rise = ctrl_write && !snapshot_request_r
                        && w_data_r[perf_monitor_pkg::CTRL_REQUEST_BIT];

  // ----------------------------------------------------------------
  // One-second timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      second_count_r <= '0;
    else if (!auto_snapshot_enable_r || second_tick)
      second_count_r <= '0;
    else
      second_count_r <= second_count_r + 32'h0000_0001;
  end

  assign second_tick = auto_snapshot_enable_r
                       && (second_count_r == 32'(SECOND_CYCLES - 1));
  assign capture     = request_rise || second_tick;

  // ----------------------------------------------------------------
  // Live counters; CRC and data service counts gated by frame format
  // ----------------------------------------------------------------
  logic is_esf;
  logic is_dd;
  assign is_esf = (format_r == perf_monitor_pkg::FMT_ESF);
  assign is_dd  = (format_r == perf_monitor_pkg::FMT_DIGITAL_DATA);

  event_counter #(.WIDTH(perf_monitor_pkg::CRC_W)) crc_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.crc_error && is_esf),
    .clear_in    (capture),
    .count_out   (live.crc)
  );

  // Same counter: F bit errors outside ESF, alignment bit errors in ESF
  event_counter #(.WIDTH(perf_monitor_pkg::FRAMING_W)) framing_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.framing_error),
    .clear_in    (capture),
    .count_out   (live.framing)
  );

  event_counter #(.WIDTH(perf_monitor_pkg::ALIGN_W)) align_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.alignment_change),
    .clear_in    (capture),
    .count_out   (live.align)
  );

  event_counter #(.WIDTH(perf_monitor_pkg::SYNC_W)) sync_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.sync_loss),
    .clear_in    (capture),
    .count_out   (live.sync)
  );

  event_counter #(.WIDTH(perf_monitor_pkg::PATTERN_W)) pattern_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.pattern_error),
    .clear_in    (capture),
    .count_out   (live.pattern)
  );

  event_counter #(.WIDTH(perf_monitor_pkg::LCV_W)) lcv_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.line_code_violation),
    .clear_in    (capture),
    .count_out   (live.line_code_violation_count)
  );

  event_counter #(.WIDTH(perf_monitor_pkg::DDS_W)) dds_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .event_in    (events_in.data_service_error && is_dd),
    .clear_in    (capture),
    .count_out   (live.dds)
  );

  // ----------------------------------------------------------------
  // Snapshot bank
  // ----------------------------------------------------------------
  // Loaded only on capture, so multi-byte reads never tear
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      snap_r <= '0;
    else if (capture)
      snap_r <= live;
  end

  // A counter at all ones means the interval may have wrapped
  assign any_full = capture && ((&live.crc) || (&live.framing) || (&live.align)
                    || (&live.sync) || (&live.pattern) || (&live.line_code_violation_count) || (&live.dds));

  // ----------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  logic [perf_monitor_pkg::IRQ_W-1:0] irq_set;
  logic [perf_monitor_pkg::IRQ_W-1:0] irq_clear;

  always_comb
  begin
    irq_set = '0;
    irq_set[perf_monitor_pkg::IRQ_SNAPSHOT_BIT] = capture;
    irq_set[perf_monitor_pkg::IRQ_WRAP_BIT]     = any_full;
    irq_clear = '0;
    if (do_write && w_strb_r[0] && (w_index == perf_monitor_pkg::IDX_IRQ_STATUS))
      irq_clear = w_data_r[perf_monitor_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_status_r <= '0;
    else
      irq_status_r <= (irq_status_r & ~irq_clear) | irq_set;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(((irq_status_r & ~irq_clear) | irq_set) & irq_mask_r);
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [5:0]  r_index;
  logic [31:0] r_word;
  logic        r_hit;
  assign r_index = s_axi_araddr[perf_monitor_pkg::INDEX_LSB +: 6];

  always_comb
  begin
    r_word = perf_monitor_pkg::ZERO_WORD;
    r_hit  = 1'b1;
    case (r_index)
      perf_monitor_pkg::IDX_CRC_LOW:      r_word[7:0] = snap_r.crc[7:0];
      perf_monitor_pkg::IDX_CRC_HIGH:
        r_word[perf_monitor_pkg::CRC_HIGH_LSB +: 2] = snap_r.crc[9:8];
      perf_monitor_pkg::IDX_FRAMING_LOW:  r_word[7:0] = snap_r.framing[7:0];
      perf_monitor_pkg::IDX_FRAMING_HIGH: r_word[3:0] = snap_r.framing[11:8];
      perf_monitor_pkg::IDX_ALIGN_CHANGE: r_word[2:0] = snap_r.align;
      perf_monitor_pkg::IDX_SYNC_LOSS:    r_word[4:0] = snap_r.sync;
      perf_monitor_pkg::IDX_PATTERN_LOW:  r_word[7:0] = snap_r.pattern[7:0];
      perf_monitor_pkg::IDX_PATTERN_HIGH: r_word[7:0] = snap_r.pattern[15:8];
      perf_monitor_pkg::IDX_LCV_LOW:      r_word[7:0] = snap_r.line_code_violation_count[7:0];
      perf_monitor_pkg::IDX_LCV_HIGH:     r_word[7:0] = snap_r.line_code_violation_count[15:8];
      perf_monitor_pkg::IDX_DDS_LOW:      r_word[7:0] = snap_r.dds[7:0];
      perf_monitor_pkg::IDX_DDS_HIGH:     r_word[1:0] = snap_r.dds[9:8];
      perf_monitor_pkg::IDX_CONTROL:
      begin
        r_word[perf_monitor_pkg::CTRL_AUTO_BIT]    = auto_snapshot_enable_r;
        r_word[perf_monitor_pkg::CTRL_REQUEST_BIT] = snapshot_request_r;
      end
      perf_monitor_pkg::IDX_FORMAT:       r_word[1:0] = format_r;
      perf_monitor_pkg::IDX_IRQ_STATUS:   r_word[perf_monitor_pkg::IRQ_W-1:0] = irq_status_r;
      perf_monitor_pkg::IDX_IRQ_MASK:     r_word[perf_monitor_pkg::IRQ_W-1:0] = irq_mask_r;
      default:                            r_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= perf_monitor_pkg::ZERO_WORD;
      s_axi_rresp   <= perf_monitor_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= r_word;
        s_axi_rresp  <= r_hit ? perf_monitor_pkg::RESP_OKAY : perf_monitor_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/perf_monitor_monitor.sv */
// Concurrent checks on the snapshot bank's register bus answers.
// Assumes it is bound to perf_monitor and sees only that module's ports.
module perf_monitor_monitor (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------
  // Indices of accepted requests
  // ------------------------
  logic [5:0] aw_idx_r;
  logic [5:0] ar_idx_r;
  logic       ar_unmapped;

  assign ar_unmapped = (s_axi_araddr[7:2] > 6'h13) || (s_axi_araddr[7:2] inside {[6'h0C:6'h0F]});

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_idx_r <= 6'h00;
      ar_idx_r <= 6'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_idx_r <= s_axi_awaddr[7:2];
      if (s_axi_arvalid && s_axi_arready)
        ar_idx_r <= s_axi_araddr[7:2];
    end
  end

  // ------------------------
  // Properties
  // ------------------------
  default clocking mon_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp changed before handshake");
  a_snapshot_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rdata changed before handshake");
  a_ar_taken: assert property ($rose(s_axi_arvalid) |=> s_axi_arready)
    else $error("arready not one cycle after arvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid not one cycle after address");
  a_ro_refused: assert property ($rose(s_axi_bvalid) && aw_idx_r <= 6'h0B |->
    s_axi_bresp == perf_monitor_pkg::RESP_SLVERR)
    else $error("snapshot write not refused");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && ar_unmapped |=>
    s_axi_rresp == perf_monitor_pkg::RESP_SLVERR && s_axi_rdata == perf_monitor_pkg::ZERO_WORD)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("read data has upper bits set");
  a_crc_high_field: assert property (s_axi_rvalid && ar_idx_r == 6'h01 |->
    s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:0] == 4'h0)
    else $error("crc high bits outside 5:4");
  a_align_field: assert property (s_axi_rvalid && ar_idx_r == 6'h04 |-> s_axi_rdata[7:3] == 5'h00)
    else $error("alignment field over three bits");
  a_dds_high_field: assert property (s_axi_rvalid && ar_idx_r == 6'h0B |-> s_axi_rdata[7:2] == 6'h00)
    else $error("data service high bits outside 1:0");

  c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == perf_monitor_pkg::RESP_SLVERR);
  c_read_refused: cover property (s_axi_rvalid && s_axi_rresp == perf_monitor_pkg::RESP_SLVERR);
  c_irq_raised: cover property ($rose(irq_out));
endmodule

bind perf_monitor perf_monitor_monitor u_monitor (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq_out(irq_out)
);

/* File: tb/perf_monitor_tb_top.sv */
// Self-checking bench for the counter snapshot bank.
// Assumes the design files and the bound checker are compiled before it.
module perf_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------
  // Signals
  // ------------------------
  // A short second keeps the automatic reload inside a short run
  localparam longint SEC = 100;
  localparam logic [1:0] OK = perf_monitor_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = perf_monitor_pkg::RESP_SLVERR;

  logic                               core_clk_in, rst_in, irq_out;
  perf_monitor_pkg::event_strobe_type events_in;
  logic [7:0]                         s_axi_awaddr, s_axi_araddr;
  logic [31:0]                        s_axi_wdata, s_axi_rdata;
  logic [3:0]                         s_axi_wstrb;
  logic [1:0]                         s_axi_bresp, s_axi_rresp;
  logic                               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                               s_axi_rvalid, s_axi_rready;
  int                                 n_fail, n_tests, cyc;
  logic [7:0]                         esf_exp [12] = '{
    8'h2C, 8'h10, 8'h04, 8'h01, 8'h05, 8'h11, 8'h2C, 8'h01, 8'h03, 8'h01, 8'h00, 8'h00};

  perf_monitor #(.SECOND_CYCLES(SEC)) dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .events_in(events_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out)
  );

  always #12.5 core_clk_in = ~core_clk_in;

  // ------------------------
  // Bus and comparison tasks
  // ------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    {aw_done, w_done} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge core_clk_in);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Late bready rises in the same cycle as bvalid, so the response is taken at once
    @(posedge core_clk_in);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk_in); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk_in);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_in); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check($sformatf("rdata %h", a), s_axi_rdata, exp);
    check($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(er));
  endtask

  // Counts in struct order: crc, framing, align, sync, pattern, line code, data service
  task automatic pulse(input int n [7]);
    int m;
    logic [6:0] v;
    m = 0;
    foreach (n[k])
      if (n[k] > m)
        m = n[k];
    for (int i = 0; i < m; i++)
    begin
      foreach (n[k])
        v[6-k] = (i < n[k]);
      events_in <= perf_monitor_pkg::event_strobe_type'(v);
      @(posedge core_clk_in);
    end
    events_in <= '0;
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    while (irq_out !== 1'b1 && c < 300)
    begin
      @(posedge core_clk_in);
      c++;
    end
  endtask

  // ------------------------
  // Scenarios
  // ------------------------
  task automatic t_reset();
    for (int i = 0; i < 20; i++)
      if (!(i inside {[12:15]}))
        rd(8'(i * 4), 32'h0000_0000, OK);
  endtask

  task automatic t_esf_snapshot();
    wr(8'h44, 32'h0000_0001, OK);
    pulse('{300, 260, 5, 17, 300, 259, 3});
    wr(8'h40, 32'h0000_0002, OK);
    for (int i = 0; i < 12; i++)
      rd(8'(i * 4), 32'(esf_exp[i]), OK);
  endtask

  task automatic t_hold_then_digital();
    wr(8'h44, 32'h0000_0002, OK);
    pulse('{7, 9, 0, 0, 0, 0, 600});
    rd(8'h00, 32'h0000_002C, OK);
    wr(8'h40, 32'h0000_0002, OK);
    rd(8'h08, 32'h0000_0004, OK);
    wr(8'h40, 32'h0000_0000, OK);
    wr(8'h40, 32'h0000_0002, OK);
    rd(8'h00, 32'h0000_0000, OK);
    rd(8'h04, 32'h0000_0000, OK);
    rd(8'h08, 32'h0000_0009, OK);
    rd(8'h28, 32'h0000_0058, OK);
    rd(8'h2C, 32'h0000_0002, OK);
  endtask

  task automatic t_refusals();
    wr(8'h08, 32'h0000_00FF, ERR);
    rd(8'h08, 32'h0000_0009, OK);
    rd(8'h30, 32'h0000_0000, ERR);
    rd(8'hFC, 32'h0000_0000, ERR);
  endtask

  task automatic t_irq();
    rd(8'h48, 32'h0000_0001, OK);
    check("irq masked", 32'(irq_out), 32'h0000_0000);
    wr(8'h4C, 32'h0000_0001, OK);
    @(posedge core_clk_in);
    check("irq unmasked", 32'(irq_out), 32'h0000_0001);
    wr(8'h48, 32'h0000_0001, OK);
    check("irq cleared", 32'(irq_out), 32'h0000_0000);
    rd(8'h48, 32'h0000_0000, OK);
  endtask

  task automatic t_auto();
    int c;
    wr(8'h40, 32'h0000_0001, OK);
    wait_irq(c);
    check("first reload", 32'(irq_out), 32'h0000_0001);
    pulse('{0, 0, 0, 4, 0, 0, 0});
    wr(8'h48, 32'h0000_0001, OK);
    wait_irq(c);
    check("reload spacing", 32'(c > 60 && c < 100), 32'h0000_0001);
    rd(8'h14, 32'h0000_0004, OK);
    wr(8'h40, 32'h0000_0000, OK);
  endtask

  // ------------------------
  // Sequence
  // ------------------------
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    events_in = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {n_fail, n_tests, cyc} = '0;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    t_reset();
    t_esf_snapshot();
    t_hold_then_digital();
    t_refusals();
    t_irq();
    t_auto();
    summarize();
  end
endmodule
